// ===== design/mas_params.svh
// Offsets, field positions, reset values and widths of the rotate/subtract/skip datapath
`ifndef MAS_PARAMS_SVH
`define MAS_PARAMS_SVH

`define MAS_OFS_CTRL      8'h00
`define MAS_OFS_WORK      8'h04
`define MAS_OFS_MEM       8'h08
`define MAS_OFS_IMM       8'h0c
`define MAS_OFS_FLAGS     8'h10
`define MAS_OFS_TPTR      8'h14
`define MAS_OFS_THIGH     8'h18
`define MAS_OFS_PAGE      8'h1c
`define MAS_OFS_STATUS    8'h20

`define MAS_CTRL_OP_LSB   0
`define MAS_CTRL_OP_MSB   4
`define MAS_CTRL_BIT_LSB  5
`define MAS_CTRL_BIT_MSB  7

`define MAS_FLG_CARRY     0
`define MAS_FLG_NIBBLE    1
`define MAS_FLG_ZERO      2
`define MAS_FLG_SIGNED    3

`define MAS_STS_SKIP      0
`define MAS_STS_MEMWR     1
`define MAS_STS_WORKWR    2

`define MAS_RST_BYTE      8'h00
`define MAS_RST_PAGE      5'h00
`define MAS_RST_FLAG      1'b0
`define MAS_ALL_ONES      8'hff
`define MAS_ONE           8'h01
`define MAS_NULL          8'h00

`define MAS_PAGE_W        5
`define MAS_LAST_PAGE     5'h1f
`define MAS_PADDR_W       13
`define MAS_PWORD_W       16

`endif

// ===== design/mas_pkg.sv
// Types of the rotate/subtract/skip datapath
`include "mas_params.svh"
package mas_pkg;

  typedef enum logic [4:0] {
    OP_ROT_LEFT, OP_ROT_LEFT_WORK, OP_ROT_LEFT_CY, OP_ROT_LEFT_CY_WORK,
    OP_ROT_RIGHT, OP_ROT_RIGHT_WORK, OP_ROT_RIGHT_CY, OP_ROT_RIGHT_CY_WORK,
    OP_SUB_BORROW, OP_SUB_BORROW_MEM, OP_SUB_PLAIN, OP_SUB_PLAIN_MEM, OP_SUB_IMM,
    OP_DEC_SKIP, OP_DEC_SKIP_WORK, OP_INC_SKIP, OP_INC_SKIP_WORK,
    OP_BIT_SKIP_SET, OP_BIT_SKIP_CLR, OP_BYTE_SKIP_NULL, OP_COPY_SKIP_NULL,
    OP_SET_BYTE, OP_SET_BIT, OP_SWAP_MEM, OP_SWAP_WORK,
    OP_TABLE_CUR, OP_TABLE_LAST, OP_XOR_WORK, OP_XOR_MEM, OP_XOR_IMM
  } mas_op_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_DUMMY, ST_TREQ, ST_TDATA
  } mas_state_e;

  typedef struct packed {
    mas_state_e                 fsm;
    mas_op_e                    op;
    logic [2:0]                 bit_idx;
    logic [7:0]                 work;
    logic [7:0]                 mem;
    logic [7:0]                 imm;
    logic [7:0]                 table_pointer;
    logic [7:0]                 table_high_latch;
    logic [`MAS_PAGE_W-1:0]     page;
    logic                       carry;
    logic                       nibble_carry_flag;
    logic                       zero;
    logic                       signed_range_flag;
    logic                       skip_seen;
    logic                       mem_wr;
    logic                       work_wr;
    logic                       skip_next;
    logic                       ack;
    logic [7:0]                 rdata;
    logic [`MAS_PADDR_W-1:0]    prog_addr;
    logic                       prog_rd;
  } mas_st_s;

endpackage

// ===== design/mas_rot8.sv
// Rotate, nibble exchange and single-bit set/test of one data byte
`timescale 1ns/1ns
module mas_rot8
  import mas_pkg::*;
(
  input  wire logic [7:0] data,
  input  wire logic       carry_in,
  input  wire logic       left,
  input  wire logic       thru,
  input  wire logic [2:0] bit_idx,
  output logic [7:0]      rotated,
  output logic            carry_out,
  output logic [7:0]      swapped,
  output logic [7:0]      bit_set,
  output logic            bit_val
);

  logic fill_l;
  logic fill_r;

  assign fill_l    = thru ? carry_in : data[7];
  assign fill_r    = thru ? carry_in : data[0];
  assign rotated   = left ? {data[6:0], fill_l} : {fill_r, data[7:1]};
  assign carry_out = left ? data[7] : data[0];
  assign swapped   = {data[3:0], data[7:4]};
  assign bit_val   = data[bit_idx];

  for (genvar i = 0; i < 8; i++)
  begin : g_bit
    assign bit_set[i] = data[i] | (bit_idx == 3'(i));
  end

endmodule

// ===== design/mas_sub8.sv
// Eight-bit subtractor with carry-as-inverted-borrow and flag outputs
`timescale 1ns/1ns
`include "mas_params.svh"
module mas_sub8
  import mas_pkg::*;
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  output logic [7:0]      diff,
  output logic            carry_out,
  output logic            nibble_borrow,
  output logic            ovf,
  output logic            zero
);

  logic [8:0] full;
  logic [4:0] low;

  // Subtraction as a + ~b + carry so carry comes out as no-borrow
  always_comb
  begin
    full          = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low           = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    diff          = full[7:0];
    carry_out     = full[8];
    nibble_borrow = ~low[4];
    ovf           = (minuend[7] ^ subtrahend[7]) & (full[7] ^ minuend[7]);
    zero          = (full[7:0] == `MAS_NULL);
  end

endmodule

// ===== design/mas_top.sv
// Execution datapath for rotates, subtracts, skips, table reads and XOR
//
// Operation
// RL1: Plain left rotate moves each bit up, bit 7 wraps to 0, no flags.
// RL2: Left rotate through carry: old carry to bit 0, old bit 7 to carry.
// RL3: Work form of carry left rotate writes work register, keeps memory byte.
// RL4: Plain right rotate wraps bit 0 to bit 7, no flags, both forms.
// RL5: Rotates aimed at work register leave the memory byte unmodified.
// RL6: Right rotate through carry: old carry to bit 7, bit 0 to carry.
// RL7: Borrow subtract is work minus memory minus inverted carry.
// RL8: Subtraction clears carry on negative result, sets it otherwise.
// RL9: Every subtract updates signed range, zero, nibble carry and carry.
// RL10: Memory-destination subtracts write the difference back to memory.
// RL11: Immediate subtract takes the constant from work into work.
// RL12: Decrement and skip when the result is zero, flags untouched.
// RL13: Increment and skip when the result wraps to zero, flags untouched.
// RL14: Work forms of inc/dec write work, keep memory, skip on result.
// RL15: A taken skip inserts one dummy cycle, two cycles in all.
// RL16: Bit test skips on bit set in one form, bit clear in other.
// RL17: Byte zero test skips on null byte; copy form also loads work.
// RL18: Byte set writes all ones; bit set forces one bit; no flags.
// RL19: Nibble exchange swaps the halves into memory or work, no flags.
// RL20: Current-page table read: low byte to memory, high to latch.
// RL21: Last-page table read splits the word from the final page.
// RL22: XOR of work with memory or immediate updates only zero flag.
// RL23: Zero marks null result; signed overflow; borrow out of bit 3.
`timescale 1ns/1ns
`include "mas_params.svh"
module mas_top
  import mas_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  output logic [`MAS_PADDR_W-1:0]      prog_addr,
  output logic                         prog_rd,
  input  wire logic [`MAS_PWORD_W-1:0] prog_rdata,
  output logic                         skip_next
);

  mas_st_s    q;
  mas_st_s    d;

  logic       req;
  logic       idle;
  logic       commit;
  logic [7:0] word_addr;
  logic [7:0] rd_mux;
  mas_op_e    new_op;

  logic       rot_left;
  logic       rot_thru;
  logic [7:0] rot_res;
  logic       rot_cout;
  logic [7:0] swap_res;
  logic [7:0] bit_res;
  logic       bit_val;

  logic [7:0] sub_rhs;
  logic       sub_cin;
  logic [7:0] sub_res;
  logic       sub_c;
  logic       sub_nb;
  logic       sub_sr;
  logic       sub_z;

  logic [7:0] dec_res;
  logic [7:0] inc_res;
  logic [7:0] xor_res;

  // Shared rotate/bit unit; direction and carry path picked from the opcode
  always_comb
  begin
    rot_left = (q.op == OP_ROT_LEFT) || (q.op == OP_ROT_LEFT_WORK) ||
               (q.op == OP_ROT_LEFT_CY) || (q.op == OP_ROT_LEFT_CY_WORK);
    rot_thru = (q.op == OP_ROT_LEFT_CY) || (q.op == OP_ROT_LEFT_CY_WORK) ||
               (q.op == OP_ROT_RIGHT_CY) || (q.op == OP_ROT_RIGHT_CY_WORK);
  end

  mas_rot8 u_rot (
    .data      (q.mem),
    .carry_in  (q.carry),
    .left      (rot_left),
    .thru      (rot_thru),
    .bit_idx   (q.bit_idx),
    .rotated   (rot_res),
    .carry_out (rot_cout),
    .swapped   (swap_res),
    .bit_set   (bit_res),
    .bit_val   (bit_val)
  );

  // Plain subtracts feed a carry of one so that no borrow is taken
  always_comb
  begin
    sub_rhs = (q.op == OP_SUB_IMM) ? q.imm : q.mem; // RL11
    sub_cin = ((q.op == OP_SUB_BORROW) || (q.op == OP_SUB_BORROW_MEM)) ?
              q.carry : 1'b1; // RL7
  end

  mas_sub8 u_sub (
    .minuend       (q.work),
    .subtrahend    (sub_rhs),
    .carry_in      (sub_cin),
    .diff          (sub_res),
    .carry_out     (sub_c),
    .nibble_borrow (sub_nb),
    .ovf           (sub_sr),
    .zero          (sub_z)
  );

  assign dec_res = q.mem - `MAS_ONE;
  assign inc_res = q.mem + `MAS_ONE;
  assign xor_res = q.work ^ ((q.op == OP_XOR_IMM) ? q.imm : q.mem); // RL22

  // Bus decode; an access to the idle datapath costs one wait state so read data leaves a flop
  assign req       = avs_read | avs_write;
  assign idle      = (q.fsm == ST_IDLE);
  assign word_addr = {avs_address[7:2], 2'b00};
  assign commit    = avs_write & q.ack & avs_byteenable[0];
  assign new_op    = mas_op_e'(avs_writedata[`MAS_CTRL_OP_MSB:`MAS_CTRL_OP_LSB]);

  always_comb
  begin
    rd_mux = `MAS_NULL;
    case (word_addr)
      `MAS_OFS_CTRL:   rd_mux = {q.bit_idx, q.op};
      `MAS_OFS_WORK:   rd_mux = q.work;
      `MAS_OFS_MEM:    rd_mux = q.mem;
      `MAS_OFS_IMM:    rd_mux = q.imm;
      `MAS_OFS_FLAGS:  rd_mux = {4'h0, q.signed_range_flag, q.zero,
                                 q.nibble_carry_flag, q.carry};
      `MAS_OFS_TPTR:   rd_mux = q.table_pointer;
      `MAS_OFS_THIGH:  rd_mux = q.table_high_latch;
      `MAS_OFS_PAGE:   rd_mux = {3'h0, q.page};
      `MAS_OFS_STATUS: rd_mux = {5'h00, q.work_wr, q.mem_wr, q.skip_seen};
      default:         rd_mux = `MAS_NULL;
    endcase
  end

  always_comb
  begin
    d           = q;
    d.prog_rd   = 1'b0;
    // Requests stall while an operation runs, so registers never change mid-access
    d.ack       = req & ~q.ack & idle;
    if (avs_read & ~q.ack & idle)
    begin
      d.rdata = rd_mux;
    end

    if (commit)
    begin
      case (word_addr)
        `MAS_OFS_CTRL:
        begin
          d.op        = new_op;
          d.bit_idx   = avs_writedata[`MAS_CTRL_BIT_MSB:`MAS_CTRL_BIT_LSB];
          d.skip_seen = 1'b0;
          d.mem_wr    = 1'b0;
          d.work_wr   = 1'b0;
          d.fsm       = ST_EXEC;
          if (new_op == OP_TABLE_CUR)
          begin
            d.fsm       = ST_TREQ;
            d.prog_rd   = 1'b1;
            d.prog_addr = {q.page, q.table_pointer}; // RL20
          end
          if (new_op == OP_TABLE_LAST)
          begin
            d.fsm       = ST_TREQ;
            d.prog_rd   = 1'b1;
            d.prog_addr = {`MAS_LAST_PAGE, q.table_pointer}; // RL21
          end
        end
        `MAS_OFS_WORK:  d.work          = avs_writedata[7:0];
        `MAS_OFS_MEM:   d.mem           = avs_writedata[7:0];
        `MAS_OFS_IMM:   d.imm           = avs_writedata[7:0];
        `MAS_OFS_TPTR:  d.table_pointer = avs_writedata[7:0];
        `MAS_OFS_PAGE:  d.page          = avs_writedata[`MAS_PAGE_W-1:0];
        `MAS_OFS_FLAGS:
        begin
          d.carry             = avs_writedata[`MAS_FLG_CARRY];
          d.nibble_carry_flag = avs_writedata[`MAS_FLG_NIBBLE];
          d.zero              = avs_writedata[`MAS_FLG_ZERO];
          d.signed_range_flag = avs_writedata[`MAS_FLG_SIGNED];
        end
        default:
        begin
        end
      endcase
    end

    unique case (q.fsm)
      ST_IDLE:
      begin
      end
      ST_EXEC:
      begin
        d.fsm = ST_IDLE;
        case (q.op)
          OP_ROT_LEFT, OP_ROT_RIGHT:
          begin
            d.mem    = rot_res; // RL1 RL4
            d.mem_wr = 1'b1;
          end
          OP_ROT_LEFT_WORK, OP_ROT_RIGHT_WORK:
          begin
            d.work    = rot_res; // RL4 RL5
            d.work_wr = 1'b1;
          end
          OP_ROT_LEFT_CY, OP_ROT_RIGHT_CY:
          begin
            d.mem    = rot_res; // RL2 RL6
            d.carry  = rot_cout;
            d.mem_wr = 1'b1;
          end
          OP_ROT_LEFT_CY_WORK, OP_ROT_RIGHT_CY_WORK:
          begin
            d.work    = rot_res; // RL3 RL5 RL6
            d.carry   = rot_cout;
            d.work_wr = 1'b1;
          end
          OP_SUB_BORROW, OP_SUB_PLAIN, OP_SUB_IMM, OP_SUB_BORROW_MEM, OP_SUB_PLAIN_MEM:
          begin
            if ((q.op == OP_SUB_BORROW_MEM) || (q.op == OP_SUB_PLAIN_MEM))
            begin
              d.mem    = sub_res; // RL10
              d.mem_wr = 1'b1;
            end
            else
            begin
              d.work    = sub_res; // RL7 RL11
              d.work_wr = 1'b1;
            end
            d.carry             = sub_c; // RL8
            d.nibble_carry_flag = sub_nb; // RL9 RL23
            d.signed_range_flag = sub_sr; // RL9 RL23
            d.zero              = sub_z; // RL9 RL23
          end
          OP_DEC_SKIP:
          begin
            d.mem       = dec_res; // RL12
            d.mem_wr    = 1'b1;
            d.skip_next = (dec_res == `MAS_NULL);
          end
          OP_DEC_SKIP_WORK:
          begin
            d.work      = dec_res; // RL14
            d.work_wr   = 1'b1;
            d.skip_next = (dec_res == `MAS_NULL);
          end
          OP_INC_SKIP:
          begin
            d.mem       = inc_res; // RL13
            d.mem_wr    = 1'b1;
            d.skip_next = (inc_res == `MAS_NULL);
          end
          OP_INC_SKIP_WORK:
          begin
            d.work      = inc_res; // RL14
            d.work_wr   = 1'b1;
            d.skip_next = (inc_res == `MAS_NULL);
          end
          OP_BIT_SKIP_SET:   d.skip_next = bit_val; // RL16
          OP_BIT_SKIP_CLR:   d.skip_next = ~bit_val; // RL16
          OP_BYTE_SKIP_NULL: d.skip_next = (q.mem == `MAS_NULL); // RL17
          OP_COPY_SKIP_NULL:
          begin
            d.work      = q.mem; // RL17
            d.work_wr   = 1'b1;
            d.skip_next = (q.mem == `MAS_NULL);
          end
          OP_SET_BYTE:
          begin
            d.mem    = `MAS_ALL_ONES; // RL18
            d.mem_wr = 1'b1;
          end
          OP_SET_BIT:
          begin
            d.mem    = bit_res; // RL18
            d.mem_wr = 1'b1;
          end
          OP_SWAP_MEM:
          begin
            d.mem    = swap_res; // RL19
            d.mem_wr = 1'b1;
          end
          OP_SWAP_WORK:
          begin
            d.work    = swap_res; // RL19
            d.work_wr = 1'b1;
          end
          OP_XOR_WORK, OP_XOR_IMM:
          begin
            d.work    = xor_res; // RL22
            d.work_wr = 1'b1;
            d.zero    = (xor_res == `MAS_NULL); // RL23
          end
          OP_XOR_MEM:
          begin
            d.mem    = xor_res; // RL22
            d.mem_wr = 1'b1;
            d.zero   = (xor_res == `MAS_NULL); // RL23
          end
          // Unused opcode codes run as an empty single cycle
          default:
          begin
          end
        endcase
        if (d.skip_next)
        begin
          d.fsm       = ST_DUMMY; // RL15
          d.skip_seen = 1'b1;
        end
      end
      ST_DUMMY:
      begin
        d.fsm       = ST_IDLE; // RL15
        d.skip_next = 1'b0;
      end
      ST_TREQ:
      begin
        d.fsm = ST_TDATA;
      end
      ST_TDATA:
      begin
        // Program memory answers one cycle after the read strobe
        d.mem              = prog_rdata[7:0]; // RL20 RL21
        d.table_high_latch = prog_rdata[15:8]; // RL20 RL21
        d.mem_wr           = 1'b1;
        d.fsm              = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q                   <= '0;
      q.fsm               <= ST_IDLE;
      q.work              <= `MAS_RST_BYTE;
      q.mem               <= `MAS_RST_BYTE;
      q.imm               <= `MAS_RST_BYTE;
      q.table_pointer     <= `MAS_RST_BYTE;
      q.table_high_latch  <= `MAS_RST_BYTE;
      q.page              <= `MAS_RST_PAGE;
      q.carry             <= `MAS_RST_FLAG;
      q.nibble_carry_flag <= `MAS_RST_FLAG;
      q.zero              <= `MAS_RST_FLAG;
      q.signed_range_flag <= `MAS_RST_FLAG;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata    = {24'h000000, q.rdata};
  assign prog_addr       = q.prog_addr;
  assign prog_rd         = q.prog_rd;
  assign skip_next       = q.skip_next;

endmodule

// ===== dv/mas_top_props.sv
// Port-level assertions for the rotate/subtract/skip datapath
`timescale 1ns/1ns
`include "mas_params.svh"
module mas_top_props
  import mas_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic [`MAS_PADDR_W-1:0] prog_addr,
  input wire logic                    prog_rd,
  input wire logic [`MAS_PWORD_W-1:0] prog_rdata,
  input wire logic                    skip_next
);
  logic                    wr_c;
  logic                    ctrl_c;
  logic                    tbl_c;
  logic                    skp_c;
  logic [4:0]              wop;
  logic [4:0]              page_m;
  logic [7:0]              tptr_m;
  logic [`MAS_PADDR_W-1:0] exp_addr_q;
  assign wr_c = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wop = avs_writedata[4:0];
  assign ctrl_c = wr_c && avs_address[7:2] == 6'h00;
  assign tbl_c = ctrl_c && (wop == 5'h19 || wop == 5'h1a);
  assign skp_c = ctrl_c && wop >= 5'h0d && wop <= 5'h14;
  // Shadow of page and pointer so the fetch address can be predicted
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      page_m <= 5'h00;
      tptr_m <= 8'h00;
      exp_addr_q <= '0;
    end
    else
    begin
      if (wr_c && avs_address[7:2] == 6'h07)
        page_m <= avs_writedata[4:0];
      if (wr_c && avs_address[7:2] == 6'h05)
        tptr_m <= avs_writedata[7:0];
      if (tbl_c)
        exp_addr_q <= {(wop == 5'h1a) ? `MAS_LAST_PAGE : page_m, tptr_m};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence table_go;
    tbl_c;
  endsequence
  sequence fetch_pulse;
    prog_rd ##1 !prog_rd;
  endsequence
  AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  AST_ANSWER: assert property ($rose(avs_read || avs_write) |-> ##[1:6] !avs_waitrequest)
    else $error("bus access not answered in time");
  AST_RD_UPPER: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_FETCH: assert property (table_go |=> fetch_pulse)
    else $error("table read did not issue one fetch strobe");
  AST_PADDR: assert property (table_go |=> prog_addr == exp_addr_q)
    else $error("table fetch address wrong");
  AST_PRD_CAUSE: assert property (prog_rd |-> $past(tbl_c))
    else $error("fetch strobe without a table read");
  AST_SKIP_ONE: assert property (skip_next |=> !skip_next)
    else $error("skip pulse longer than one cycle");
  AST_SKIP_CAUSE: assert property (skip_next |-> $past(skp_c) || $past(skp_c, 2))
    else $error("skip without a skip-class operation");
  AST_NO_SKIP: assert property (ctrl_c && !skp_c |=> !skip_next [*2])
    else $error("skip from a non-skip operation");
endmodule
bind mas_top mas_top_props u_props (.clk(clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_rd(prog_rd),
  .prog_rdata(prog_rdata), .skip_next(skip_next));

// ===== dv/test_mcu_alu_rotate_sub_skip_ops.sv
// Register-level testbench of the rotate/subtract/skip datapath
`timescale 1ns/1ns
`include "mas_params.svh"
module test_mcu_alu_rotate_sub_skip_ops
  import mas_pkg::*;
;
  logic                    clk;
  logic                    nrst;
  logic [7:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [`MAS_PADDR_W-1:0] prog_addr;
  logic                    prog_rd;
  logic [`MAS_PWORD_W-1:0] prog_rdata = '0;
  logic                    skip_next;
  int                      bad_count;
  int                      n_checks;
  logic [31:0]             q;
  logic [15:0]             w16;
  logic [30:0]             pat [6];
  mas_top dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_rdata(prog_rdata), .skip_next(skip_next));
  always #4 clk = ~clk;
  function automatic logic [15:0] rom(input logic [12:0] a);
    return {3'h0, a} ^ 16'ha55a;
  endfunction
  // Synchronous program store; the bus toggles between fetches so stale data never matches
  always @(posedge clk)
    prog_rdata <= prog_rd ? rom(prog_addr) : ~prog_rdata;
  task automatic test_done;
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      bad_count++;
      test_done;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q[7:0]);
  endtask
  // Reference result: {skip, flags, mem, work}
  function automatic logic [20:0] model(input logic [4:0] op, input logic [2:0] b,
    input logic [7:0] w, input logic [7:0] m, input logic [7:0] i, input logic [3:0] f);
    logic [7:0] r;
    logic [7:0] x;
    logic [8:0] s;
    logic [4:0] h;
    logic       c;
    logic       sk;
    r = m;
    sk = 1'b0;
    x = (op == 5'd12 || op == 5'd29) ? i : m;
    c = (op == 5'd8 || op == 5'd9) ? f[0] : 1'b1;
    case (op) inside
      [5'd0:5'd1]: r = {m[6:0], m[7]};
      [5'd2:5'd3]: {f[0], r} = {m, f[0]};
      [5'd4:5'd5]: r = {m[0], m[7:1]};
      [5'd6:5'd7]: {r, f[0]} = {f[0], m};
      [5'd8:5'd12]:
      begin
        s = {1'b0, w} + {1'b0, ~x} + {8'h0, c};
        h = {1'b0, w[3:0]} + {1'b0, ~x[3:0]} + {4'h0, c};
        r = s[7:0];
        f = {(w[7] != x[7]) && (r[7] != w[7]), r == 8'h00, ~h[4], s[8]};
      end
      [5'd13:5'd14]: r = m - 8'h01;
      [5'd15:5'd16]: r = m + 8'h01;
      5'd21: r = 8'hff;
      5'd22: r[b] = 1'b1;
      [5'd23:5'd24]: r = {m[3:0], m[7:4]};
      [5'd27:5'd29]:
      begin
        r = w ^ x;
        f[2] = r == 8'h00;
      end
      default: r = m;
    endcase
    if (op >= 5'd13 && op <= 5'd16 || op >= 5'd19 && op <= 5'd20)
      sk = r == 8'h00;
    if (op == 5'd17 || op == 5'd18)
      sk = m[b] ^ (op == 5'd18);
    return {sk, f, (32'h10e0aa55 >> op) & 1 ? r : m, (32'h291155aa >> op) & 1 ? r : w};
  endfunction
  task automatic run(input logic [4:0] op, input logic [30:0] p);
    logic [20:0] e;
    int          sk;
    e = model(op, p[30:28], p[7:0], p[15:8], p[23:16], p[27:24]);
    bus(1'b1, `MAS_OFS_WORK, p[7:0]);
    bus(1'b1, `MAS_OFS_MEM, p[15:8]);
    bus(1'b1, `MAS_OFS_IMM, p[23:16]);
    bus(1'b1, `MAS_OFS_FLAGS, {4'h0, p[27:24]});
    bus(1'b1, `MAS_OFS_CTRL, {p[30:28], op});
    sk = 0;
    repeat (3)
    begin
      @(posedge clk);
      if (skip_next === 1'b1)
        sk++;
    end
    chk("skip pulses", {7'h0, e[20]}, sk[7:0]);
    rdc(`MAS_OFS_WORK, e[7:0], "work");
    rdc(`MAS_OFS_MEM, e[15:8], "mem");
    bus(1'b0, `MAS_OFS_FLAGS, 8'h00);
    chk("flags", {4'h0, e[19:16]}, {4'h0, q[3:0]});
    rdc(`MAS_OFS_STATUS, {5'h0, 1'(32'h291155aa >> op), 1'(32'h10e0aa55 >> op),
      e[20]}, "status");
  endtask
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    bad_count = 0;
    n_checks = 0;
    // Carry in, overflow, null result, borrow and wrap cases, plus both bit polarities
    pat = '{{3'd0, 4'h1, 8'h7f, 8'h81, 8'h3c}, {3'd7, 4'h0, 8'h80, 8'h01, 8'h80},
      {3'd3, 4'hf, 8'h10, 8'h10, 8'h10}, {3'd5, 4'h0, 8'h06, 8'h00, 8'h05},
      {3'd2, 4'h1, 8'h00, 8'hff, 8'h00}, {3'd0, 4'h2, 8'h01, 8'h01, 8'h01}};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 36; a += 4)
      rdc(a[7:0], 8'h00, "reset value");
    for (int p = 0; p < 6; p++)
      for (int op = 0; op < 32; op++)
        if (op != 25 && op != 26)
          run(op[4:0], pat[p]);
    for (int t = 0; t < 2; t++)
    begin
      w16 = rom({t ? `MAS_LAST_PAGE : 5'h0a, 8'hc5 + t[7:0]});
      bus(1'b1, `MAS_OFS_PAGE, 8'h0a);
      bus(1'b1, `MAS_OFS_TPTR, 8'hc5 + t[7:0]);
      bus(1'b1, `MAS_OFS_CTRL, 8'h19 + t[7:0]);
      rdc(`MAS_OFS_MEM, w16[7:0], "table low byte");
      bus(1'b1, `MAS_OFS_THIGH, 8'h00);
      rdc(`MAS_OFS_THIGH, w16[15:8], "table high byte");
    end
    bus(1'b1, `MAS_OFS_WORK, 8'h5a);
    avs_byteenable <= 4'he;
    bus(1'b1, `MAS_OFS_WORK, 8'h77);
    avs_byteenable <= 4'hf;
    rdc(`MAS_OFS_WORK, 8'h5a, "lane-masked write");
    bus(1'b1, 8'h24, 8'hff);
    rdc(8'h24, 8'h00, "unmapped");
    test_done;
  end
endmodule
